// *** include/gidc_chan_if.sv ***
`timescale 1ns/10ps
`default_nettype none

// Link between the register file and one trigger channel
interface gidc_chan_if;
    gidc_pkg::gidc_chan_cfg_t cfg;
    logic pin;
    logic trig;

    modport ctrl (output cfg, output pin, input trig);
    modport chan (input cfg, input pin, output trig);
endinterface : gidc_chan_if

`default_nettype wire

// *** include/gidc_defs.svh ***
`ifndef GIDC_DEFS_SVH
`define GIDC_DEFS_SVH

// Register byte addresses
`define GIDC_ADDR_PENDING 32'h4000a814
`define GIDC_ADDR_CFG_A 32'h4000a860
`define GIDC_ADDR_CFG_B 32'h4000a864
`define GIDC_ADDR_CFG_C 32'h4000a868
`define GIDC_ADDR_CFG_D 32'h4000a86c
`define GIDC_ADDR_DBG_CFG 32'h4000bc00
`define GIDC_ADDR_DBG_STAT 32'h4000bc04
`define GIDC_ADDR_SEL_C 32'h4000bc14
`define GIDC_ADDR_SEL_D 32'h4000bc18

// Field positions
`define GIDC_CFG_FILT_BIT 8
`define GIDC_CFG_MODE_HI 7
`define GIDC_CFG_MODE_LO 5
`define GIDC_DBG_DIS_BIT 5
`define GIDC_DBG_REG_BIT 4
`define GIDC_DBG_RSVD_BIT 3
`define GIDC_STAT_BOOT_BIT 3
`define GIDC_STAT_FORCED_BIT 1
`define GIDC_STAT_SWEN_BIT 0
`define GIDC_SEL_W 5
`define GIDC_NUM_PINS 24
`define GIDC_NUM_CH 4

// Reset values
`define GIDC_RST_PENDING 4'h0
`define GIDC_RST_DBG_CFG 32'h00000010
`define GIDC_RST_SEL_C 5'h0f
`define GIDC_RST_SEL_D 5'h10

// Timing
`define GIDC_CLK_PERIOD_NS 40
`define GIDC_FILTER_NS 160
`define GIDC_FILTER_CYC ((`GIDC_FILTER_NS + `GIDC_CLK_PERIOD_NS - 1) / `GIDC_CLK_PERIOD_NS)
`define GIDC_FILT_CNT_W 3
`define GIDC_BOOT_SETTLE_CYC 2

`endif

// *** include/gidc_pkg.sv ***
package gidc_pkg;

    // Trigger mode codes
    typedef enum logic [2:0] {
        GIDC_MODE_OFF = 3'h0,
        GIDC_MODE_RISE = 3'h1,
        GIDC_MODE_FALL = 3'h2,
        GIDC_MODE_BOTH = 3'h3,
        GIDC_MODE_HIGH = 3'h4,
        GIDC_MODE_LOW = 3'h5,
        GIDC_MODE_RSV6 = 3'h6,
        GIDC_MODE_RSV7 = 3'h7
    } gidc_mode_t;

    // One channel's configuration
    typedef struct packed {
        logic filt_en;
        gidc_mode_t mode;
    } gidc_chan_cfg_t;

    typedef logic [4:0] gidc_pin_sel_t;

endpackage : gidc_pkg

// *** sim/gidc_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "gidc_defs.svh"

module gidc_checker (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pslverr_out,
    input wire logic debugger_forced_active_in,
    input wire logic serial_wire_enabled_in,
    input wire logic [3:0] ext_irq_pending_out,
    input wire logic debug_enable_out,
    input wire logic ext_regulator_override_enable_out,
    input wire gidc_pkg::gidc_pin_sel_t irq_c_select_out
);
    import gidc_pkg::*;
    logic wr, rd, wr_pend, wr_dbg, rd_stat, rd_cfg;

    // Bus phase decode
    assign wr = psel_in && penable_in && pwrite_in;
    assign rd = psel_in && !penable_in && !pwrite_in;
    assign wr_pend = wr && paddr_in == `GIDC_ADDR_PENDING;
    assign wr_dbg = wr && paddr_in == `GIDC_ADDR_DBG_CFG;
    assign rd_stat = rd && paddr_in == `GIDC_ADDR_DBG_STAT;
    assign rd_cfg = rd && paddr_in[31:4] == 28'h4000a86;

    default clocking @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    AST_FLAG_HOLD: assert property (((~ext_irq_pending_out & $past(ext_irq_pending_out))
        & ~($past(pwdata_in[3:0]) & {4{$past(wr_pend)}})) == 4'h0)
        else $error("pending flag fell without a clearing write");
    AST_DBG_PERMIT: assert property (wr_dbg && !pwdata_in[5] |-> ##2 debug_enable_out)
        else $error("debug not permitted after disable cleared");
    AST_REG_OVR: assert property (wr_dbg |=>
        ext_regulator_override_enable_out == $past(pwdata_in[4]))
        else $error("regulator override does not follow write");
    AST_STAT_FORCED: assert property (rd_stat |=>
        prdata_out[1] == $past(debugger_forced_active_in, 3))
        else $error("forced status bit wrong");
    AST_STAT_SWEN: assert property (rd_stat |=>
        prdata_out[0] == $past(serial_wire_enabled_in, 3))
        else $error("serial wire status bit wrong");
    AST_STAT_ZERO: assert property (rd_stat |=> prdata_out[31:4] == 28'h0 && !prdata_out[2])
        else $error("status unused bits not zero");
    AST_CFG_ZERO: assert property (rd_cfg |=>
        prdata_out[31:9] == 23'h0 && prdata_out[4:0] == 5'h0)
        else $error("config unused bits not zero");
    AST_SEL_C: assert property (wr && paddr_in == `GIDC_ADDR_SEL_C |=>
        irq_c_select_out == $past(pwdata_in[4:0]))
        else $error("selector C does not follow write");

    // Main scenarios reached
    cover property ($rose(ext_irq_pending_out[0]));
    cover property (wr_pend && pwdata_in[3:0] != 4'h0);
    cover property (psel_in && penable_in && pslverr_out);
endmodule : gidc_checker

`default_nettype wire

// *** sim/gidc_pins_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module gidc_pins_model (
    input wire logic clk_in,
    input wire logic [29:0] lvl_in,
    output logic [29:0] pins_out
);
    // Board levels settle just after an edge, like pads
    always @(posedge clk_in)
        pins_out <= lvl_in;
endmodule : gidc_pins_model

`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "gidc_defs.svh"

module testbench;
    import gidc_pkg::*;
    localparam logic [31:0] PEND = `GIDC_ADDR_PENDING;
    localparam logic [31:0] CFGA = `GIDC_ADDR_CFG_A;
    localparam logic [31:0] DBG = `GIDC_ADDR_DBG_CFG;
    localparam logic [31:0] STAT = `GIDC_ADDR_DBG_STAT;
    localparam logic [31:0] SELC = `GIDC_ADDR_SEL_C;
    localparam logic [31:0] RA [9] = '{PEND, CFGA, CFGA + 4, CFGA + 8, CFGA + 12, DBG, STAT,
        SELC, SELC + 4};
    localparam logic [31:0] RV [9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h10, 32'h8,
        32'hf, 32'h10};
    logic clk_in, rst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, e;
    logic [31:0] paddr_in, pwdata_in, prdata_out, q, s;
    logic [29:0] lvl, pins;
    logic [3:0] ext_irq_pending_out;
    logic debug_enable_out, ext_regulator_override_enable_out;
    gidc_pin_sel_t irq_c_select_out, irq_d_select_out;
    logic [4:0] sel [4];
    int n_errors, num_checks;

    gidc_pins_model pm_u (.clk_in, .lvl_in(lvl), .pins_out(pins));
    gidc_top dut_u (.clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
        .ext_interrupt_a_in(pins[0]), .ext_interrupt_b_in(pins[1]),
        .gpio_pins_in(pins[25:2]), .boot_select_pin_n_in(pins[26]),
        .debugger_forced_active_in(pins[27]), .serial_wire_enabled_in(pins[28]),
        .debug_cfg_reserved_bit_in(pins[29]), .ext_irq_pending_out, .debug_enable_out,
        .ext_regulator_override_enable_out, .irq_c_select_out, .irq_d_select_out);

    // Clock and watchdog
    initial
    begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    initial
    begin
        #400us;
        n_errors++;
        end_sim;
    end

    task end_sim;
        if (n_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (g !== x)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, x, g);
        end
    endtask : chk

    // One bus transfer; holds the request until pready is seen high
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        // No local limit: only the watchdog ends a wait that never answers
        do
        begin
            @(posedge clk_in);
        end
        while (pready_out !== 1'b1);
        q = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : xfer

    function logic trig(input int m, input logic o, input logic n);
        case (m)
            1: return !o && n;
            2: return o && !n;
            3: return o != n;
            4: return o || n;
            5: return !o || !n;
            default: return 1'b0;
        endcase
    endfunction : trig

    // Pin moves from o to n (optionally back after g cycles), flag checked
    task trial(input int ch, input int m, input logic f, input logic o, input logic n,
        input int g);
        int p;
        logic x;
        p = ch < 2 ? ch : 2 + sel[ch];
        lvl[p] <= o;
        xfer(1'b1, CFGA + 4 * ch, 32'({f, m[2:0], 5'h0}));
        repeat (12) @(posedge clk_in);
        xfer(1'b1, PEND, 32'hf);
        lvl[p] <= n;
        if (g > 0)
        begin
            repeat (g) @(posedge clk_in);
            lvl[p] <= o;
        end
        repeat (12) @(posedge clk_in);
        x = (f && g > 0) ? 1'b0 : trig(m, o, n);
        xfer(1'b0, PEND, 32'h0);
        chk("pending", 32'(x) << ch, q);
        chk("pending_port", 32'(x) << ch, 32'(ext_irq_pending_out));
        xfer(1'b1, CFGA + 4 * ch, 32'h0);
    endtask : trial

    // Main sequence
    initial
    begin
        s = $urandom(32'he0da);
        {rst_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = 68'h8_0000_0000_0000_0000;
        lvl = 30'h0;
        sel[2] = 5'h0f;
        sel[3] = 5'h10;
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        chk("reg_ovr", 32'h1, 32'(ext_regulator_override_enable_out));
        repeat (4) @(posedge clk_in);
        for (int i = 0; i < 9; i++)
        begin
            xfer(1'b0, RA[i], 32'h0);
            chk("reset_value", RV[i], q);
        end
        for (int c = 2; c < 4; c++)
        begin
            sel[c] = 5'($urandom % 24);
            xfer(1'b1, SELC + 4 * (c - 2), {27'($urandom), sel[c]});
            xfer(1'b0, SELC + 4 * (c - 2), 32'h0);
            chk("select", 32'(sel[c]), q);
        end
        chk("sel_d_port", 32'(sel[3]), 32'(irq_d_select_out));
        for (int i = 0; i < 16; i++)
        begin
            s = $urandom;
            xfer(1'b1, CFGA + 4 * (i % 4), s);
            xfer(1'b0, CFGA + 4 * (i % 4), 32'h0);
            chk("config", s & 32'h1e0, q);
            xfer(1'b1, CFGA + 4 * (i % 4), 32'h0);
        end
        for (int k = 0; k < 32; k++)
            trial($urandom % 4, k / 4, 1'($urandom), k[1], k[0], 0);
        trial(0, 1, 1'b0, 1'b0, 1'b1, 2);
        trial(0, 1, 1'b1, 1'b0, 1'b1, 2);
        // Out-of-range selector reads as a steady low pin
        xfer(1'b1, SELC + 4, 32'h18);
        for (int m = 4; m < 6; m++)
        begin
            xfer(1'b1, CFGA + 12, 32'(m) << 5);
            repeat (12) @(posedge clk_in);
            xfer(1'b1, PEND, 32'hf);
            repeat (4) @(posedge clk_in);
            xfer(1'b0, PEND, 32'h0);
            chk("reserved_select", m == 5 ? 32'h8 : 32'h0, q);
        end
        xfer(1'b1, CFGA + 12, 32'h0);
        // Partial clears of two set flags
        lvl[1:0] <= 2'b00; // Both pins low first so the later rise is real
        xfer(1'b1, CFGA, 32'h20);
        xfer(1'b1, CFGA + 4, 32'h20);
        xfer(1'b1, PEND, 32'hf);
        lvl[1:0] <= 2'b11;
        repeat (8) @(posedge clk_in);
        for (int i = 0; i < 3; i++)
        begin
            xfer(1'b1, PEND, i == 0 ? 32'h0 : (i == 1 ? 32'h1 : 32'hfffffff2));
            xfer(1'b0, PEND, 32'h0);
            chk("w1c", i == 0 ? 32'h3 : (i == 1 ? 32'h2 : 32'h0), q);
        end
        // Debug disable, regulator override, reserved bit kept by read-modify-write
        lvl[29] <= 1'b1;
        repeat (6) @(posedge clk_in);
        xfer(1'b0, DBG, 32'h0);
        chk("dbg_cfg", 32'h18, q);
        xfer(1'b1, DBG, q | 32'h20);
        repeat (3) @(posedge clk_in);
        chk("dbg_en", 32'h0, 32'(debug_enable_out));
        lvl[27] <= 1'b1;
        repeat (6) @(posedge clk_in);
        chk("dbg_en", 32'h0, 32'(debug_enable_out));
        xfer(1'b0, DBG, 32'h0);
        xfer(1'b1, DBG, q ^ 32'h38);
        repeat (3) @(posedge clk_in);
        chk("dbg_en", 32'h1, 32'(debug_enable_out));
        chk("reg_ovr", 32'h0, 32'(ext_regulator_override_enable_out));
        xfer(1'b0, DBG, 32'h0);
        chk("dbg_cfg", 32'h8, q);
        xfer(1'b1, DBG, q | 32'h20);
        repeat (3) @(posedge clk_in);
        chk("dbg_en", 32'h1, 32'(debug_enable_out));
        // Status follows the debugger lines and ignores writes
        for (int i = 0; i < 4; i++)
        begin
            lvl[28:27] <= 2'($urandom);
            repeat (6) @(posedge clk_in);
            xfer(1'b1, STAT, 32'hffffffff);
            xfer(1'b0, STAT, 32'h0);
            chk("status", {28'h0, 2'b10, lvl[27], lvl[28]}, q);
        end
        xfer(1'b0, 32'h4000a818, 32'h0);
        chk("slverr", 32'h1, 32'(e));
        chk("unmapped", 32'h0, q);
        // Second reset with the boot pin released
        lvl[26] <= 1'b1;
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (5) @(posedge clk_in);
        xfer(1'b0, STAT, 32'h0);
        chk("boot", 32'h0, q & 32'h8);
        end_sim;
    end
endmodule : testbench

bind gidc_top gidc_checker chk_u (.clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pslverr_out, .debugger_forced_active_in,
    .serial_wire_enabled_in, .ext_irq_pending_out, .debug_enable_out,
    .ext_regulator_override_enable_out, .irq_c_select_out);

`default_nettype wire

// *** verilog/gidc_chan.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "gidc_defs.svh"

module gidc_chan (
    input wire logic clk_in,
    input wire logic rst_in,
    gidc_chan_if.chan link
);
    import gidc_pkg::*;

    localparam logic [`GIDC_FILT_CNT_W-1:0] FILT_LAST =
        `GIDC_FILT_CNT_W'(`GIDC_FILTER_CYC - 1);

    logic [`GIDC_FILT_CNT_W-1:0] filt_cnt_ff, nxt_filt_cnt;
    logic filt_lvl_ff, nxt_filt_lvl;
    logic prev_ff, nxt_prev;
    logic level;

    // Digital filter: new level only after it holds for the full count
    always_comb
    begin
        nxt_filt_cnt = '0;
        nxt_filt_lvl = link.pin;
        if (link.cfg.filt_en)
        begin
            nxt_filt_lvl = filt_lvl_ff;
            if (link.pin != filt_lvl_ff)
            begin
                if (filt_cnt_ff == FILT_LAST)
                begin
                    nxt_filt_lvl = link.pin;
                end
                else
                begin
                    nxt_filt_cnt = filt_cnt_ff + 1'b1;
                end
            end
        end
        level = link.cfg.filt_en ? filt_lvl_ff : link.pin;
        nxt_prev = level;
    end

    // Trigger condition per mode; reserved codes never fire
    always_comb
    begin
        unique case (link.cfg.mode)
            GIDC_MODE_OFF: link.trig = 1'b0;
            GIDC_MODE_RISE: link.trig = level & ~prev_ff;
            GIDC_MODE_FALL: link.trig = ~level & prev_ff;
            GIDC_MODE_BOTH: link.trig = level ^ prev_ff;
            GIDC_MODE_HIGH: link.trig = level;
            GIDC_MODE_LOW: link.trig = ~level;
            default: link.trig = 1'b0;
        endcase
    end

    // Filter and edge history registers
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            filt_cnt_ff <= '0;
            filt_lvl_ff <= 1'b0;
            prev_ff <= 1'b0;
        end
        else
        begin
            filt_cnt_ff <= nxt_filt_cnt;
            filt_lvl_ff <= nxt_filt_lvl;
            prev_ff <= nxt_prev;
        end
    end

endmodule : gidc_chan

`default_nettype wire

// *** verilog/gidc_top.sv ***
// Behaviour
// - Config bit 8 enables digital filtering of that channel's input.
// - Mode bits 7:5: 0 off, 1 rising, 2 falling, 3 both edges.
// - Mode 4 triggers while high, 5 while low; 6 and 7 reserved.
// - Pending flags A..D at bits 0..3; write one clears, zero keeps.
// - Debug disable bit 5 blocks debug activation unless already active.
// - Debug config bit 4 enables regulator override of port A pin 7; resets set.
// - Status bit 3 shows boot pin asserted low, sampled after reset.
// - Status bit 1 shows the debugger cable forced debug active.
// - Status bit 0 shows serial wire enabled by the debug port.
// - Channels C and D pick their pin by 5-bit selector; high codes reserved.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "gidc_defs.svh"

module gidc_top (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic ext_interrupt_a_in,
    input wire logic ext_interrupt_b_in,
    input wire logic [23:0] gpio_pins_in,
    input wire logic boot_select_pin_n_in,
    input wire logic debugger_forced_active_in,
    input wire logic serial_wire_enabled_in,
    input wire logic debug_cfg_reserved_bit_in,
    output logic [3:0] ext_irq_pending_out,
    output logic debug_enable_out,
    output logic ext_regulator_override_enable_out,
    output gidc_pkg::gidc_pin_sel_t irq_c_select_out,
    output gidc_pkg::gidc_pin_sel_t irq_d_select_out
);
    import gidc_pkg::*;

    localparam logic [31:0] DBG_RST = `GIDC_RST_DBG_CFG;
    localparam int IDX_A = 0;
    localparam int IDX_B = 1;
    localparam int IDX_BOOT = 2;
    localparam int IDX_FORCED = 3;
    localparam int IDX_SWEN = 4;
    localparam int IDX_RSVD = 5;
    localparam int MISC_W = 6;
    localparam logic [1:0] BOOT_SETTLE = 2'(`GIDC_BOOT_SETTLE_CYC);
    localparam gidc_pin_sel_t PIN_LIMIT = 5'(`GIDC_NUM_PINS);

    // Synchroniser stages
    logic [`GIDC_NUM_PINS-1:0] gpio_meta_ff, gpio_sync_ff;
    logic [MISC_W-1:0] misc_meta_ff, misc_sync_ff;

    // Bus side
    logic [31:0] prdata_ff, nxt_prdata;
    logic pslverr_ff, nxt_pslverr;
    logic [31:0] rd_word;
    logic addr_ok;
    logic setup_phase;
    logic wr_go;

    // Configuration storage
    gidc_chan_cfg_t cfg_ff [`GIDC_NUM_CH];
    gidc_chan_cfg_t nxt_cfg [`GIDC_NUM_CH];
    gidc_pin_sel_t sel_c_ff, nxt_sel_c;
    gidc_pin_sel_t sel_d_ff, nxt_sel_d;
    logic dbg_dis_ff, nxt_dbg_dis;
    logic ext_reg_ff, nxt_ext_reg;
    logic dbg_en_ff, nxt_dbg_en;

    // Flags and status
    logic [`GIDC_NUM_CH-1:0] pending_ff, nxt_pending;
    logic [`GIDC_NUM_CH-1:0] chan_trig;
    logic [`GIDC_NUM_CH-1:0] chan_pin;
    logic [`GIDC_NUM_CH-1:0] cfg_wr;
    logic [1:0] boot_cnt_ff, nxt_boot_cnt;
    logic boot_done_ff, nxt_boot_done;
    logic boot_pin_sampled_ff, nxt_boot_pin_sampled;
    logic debug_active;

    // Two-stage synchronisers for every pin and debug status input
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            gpio_meta_ff <= '0;
            gpio_sync_ff <= '0;
            misc_meta_ff <= '0;
            misc_sync_ff <= '0;
        end
        else
        begin
            gpio_meta_ff <= gpio_pins_in;
            gpio_sync_ff <= gpio_meta_ff;
            misc_meta_ff <= {debug_cfg_reserved_bit_in, serial_wire_enabled_in,
                debugger_forced_active_in, boot_select_pin_n_in,
                ext_interrupt_b_in, ext_interrupt_a_in};
            misc_sync_ff <= misc_meta_ff;
        end
    end

    // Pin picked by a selector; reserved codes give a quiet low input
    function automatic logic pick_pin(input gidc_pin_sel_t sel,
        input logic [`GIDC_NUM_PINS-1:0] pins);
        logic [`GIDC_NUM_PINS-1:0] shifted;
        shifted = pins >> sel;
        pick_pin = (sel < PIN_LIMIT) ? shifted[0] : 1'b0;
    endfunction : pick_pin

    // Channel input routing
    always_comb
    begin
        chan_pin[0] = misc_sync_ff[IDX_A];
        chan_pin[1] = misc_sync_ff[IDX_B];
        chan_pin[2] = pick_pin(sel_c_ff, gpio_sync_ff);
        chan_pin[3] = pick_pin(sel_d_ff, gpio_sync_ff);
    end

    // Bus decode and read multiplexer
    always_comb
    begin
        setup_phase = psel_in & ~penable_in;
        addr_ok = 1'b1;
        rd_word = '0;
        cfg_wr = '0;
        unique case (paddr_in)
            `GIDC_ADDR_PENDING:
            begin
                rd_word[`GIDC_NUM_CH-1:0] = pending_ff;
            end
            `GIDC_ADDR_CFG_A, `GIDC_ADDR_CFG_B, `GIDC_ADDR_CFG_C, `GIDC_ADDR_CFG_D:
            begin
                rd_word[`GIDC_CFG_FILT_BIT] = cfg_ff[paddr_in[3:2]].filt_en;
                rd_word[`GIDC_CFG_MODE_HI:`GIDC_CFG_MODE_LO] =
                    cfg_ff[paddr_in[3:2]].mode;
                cfg_wr[paddr_in[3:2]] = 1'b1;
            end
            `GIDC_ADDR_SEL_C:
            begin
                rd_word[`GIDC_SEL_W-1:0] = sel_c_ff;
            end
            `GIDC_ADDR_SEL_D:
            begin
                rd_word[`GIDC_SEL_W-1:0] = sel_d_ff;
            end
            `GIDC_ADDR_DBG_CFG:
            begin
                rd_word[`GIDC_DBG_DIS_BIT] = dbg_dis_ff;
                rd_word[`GIDC_DBG_REG_BIT] = ext_reg_ff;
                rd_word[`GIDC_DBG_RSVD_BIT] = misc_sync_ff[IDX_RSVD];
            end
            `GIDC_ADDR_DBG_STAT:
            begin
                rd_word[`GIDC_STAT_BOOT_BIT] = boot_pin_sampled_ff;
                rd_word[`GIDC_STAT_FORCED_BIT] = misc_sync_ff[IDX_FORCED];
                rd_word[`GIDC_STAT_SWEN_BIT] = misc_sync_ff[IDX_SWEN];
            end
            default:
            begin
                addr_ok = 1'b0;
            end
        endcase
        wr_go = psel_in & penable_in & pwrite_in & addr_ok;
        nxt_prdata = prdata_ff;
        nxt_pslverr = pslverr_ff;
        if (setup_phase)
        begin
            nxt_prdata = (addr_ok & ~pwrite_in) ? rd_word : '0;
            nxt_pslverr = ~addr_ok;
        end
    end

    // Bus answer registers
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            prdata_ff <= '0;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            prdata_ff <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // Zero-wait slave; error only shown in the access phase
    assign pready_out = 1'b1;
    assign pslverr_out = pslverr_ff & psel_in & penable_in;
    assign prdata_out = prdata_ff;

    // Per-channel configuration register and trigger logic
    generate
        for (genvar ch = 0; ch < `GIDC_NUM_CH; ch++)
        begin : g_chan
            gidc_chan_if link ();

            always_comb
            begin
                nxt_cfg[ch] = cfg_ff[ch];
                if (wr_go && cfg_wr[ch])
                begin
                    nxt_cfg[ch].filt_en = pwdata_in[`GIDC_CFG_FILT_BIT];
                    nxt_cfg[ch].mode = gidc_mode_t'(
                        pwdata_in[`GIDC_CFG_MODE_HI:`GIDC_CFG_MODE_LO]);
                end
            end

            always_ff @(posedge clk_in or posedge rst_in)
            begin
                if (rst_in)
                begin
                    cfg_ff[ch] <= '0;
                end
                else
                begin
                    cfg_ff[ch] <= nxt_cfg[ch];
                end
            end

            assign link.cfg = cfg_ff[ch];
            assign link.pin = chan_pin[ch];
            assign chan_trig[ch] = link.trig;

            gidc_chan u_chan (
                .clk_in(clk_in),
                .rst_in(rst_in),
                .link(link.chan)
            );
        end
    endgenerate

    // Pending flags, C/D selectors and debug configuration
    always_comb
    begin
        nxt_pending = pending_ff;
        if (wr_go && (paddr_in == `GIDC_ADDR_PENDING))
        begin
            nxt_pending = pending_ff & ~pwdata_in[`GIDC_NUM_CH-1:0];
        end
        nxt_pending = nxt_pending | chan_trig;
        nxt_sel_c = sel_c_ff;
        nxt_sel_d = sel_d_ff;
        if (wr_go && (paddr_in == `GIDC_ADDR_SEL_C))
        begin
            nxt_sel_c = pwdata_in[`GIDC_SEL_W-1:0];
        end
        if (wr_go && (paddr_in == `GIDC_ADDR_SEL_D))
        begin
            nxt_sel_d = pwdata_in[`GIDC_SEL_W-1:0];
        end
        nxt_dbg_dis = dbg_dis_ff;
        nxt_ext_reg = ext_reg_ff;
        if (wr_go && (paddr_in == `GIDC_ADDR_DBG_CFG))
        begin
            nxt_dbg_dis = pwdata_in[`GIDC_DBG_DIS_BIT];
            nxt_ext_reg = pwdata_in[`GIDC_DBG_REG_BIT];
        end
        // Debug stays usable while disabled only if it was already up
        debug_active = misc_sync_ff[IDX_FORCED] | misc_sync_ff[IDX_SWEN];
        nxt_dbg_en = ~dbg_dis_ff | (dbg_en_ff & debug_active);
    end

    // Configuration and flag registers
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pending_ff <= `GIDC_RST_PENDING;
            sel_c_ff <= `GIDC_RST_SEL_C;
            sel_d_ff <= `GIDC_RST_SEL_D;
            dbg_dis_ff <= DBG_RST[`GIDC_DBG_DIS_BIT];
            ext_reg_ff <= DBG_RST[`GIDC_DBG_REG_BIT];
            dbg_en_ff <= 1'b1;
        end
        else
        begin
            pending_ff <= nxt_pending;
            sel_c_ff <= nxt_sel_c;
            sel_d_ff <= nxt_sel_d;
            dbg_dis_ff <= nxt_dbg_dis;
            ext_reg_ff <= nxt_ext_reg;
            dbg_en_ff <= nxt_dbg_en;
        end
    end

    // Boot pin capture once the synchroniser has settled after reset
    always_comb
    begin
        nxt_boot_cnt = boot_cnt_ff;
        nxt_boot_done = boot_done_ff;
        nxt_boot_pin_sampled = boot_pin_sampled_ff;
        if (!boot_done_ff)
        begin
            if (boot_cnt_ff == BOOT_SETTLE)
            begin
                nxt_boot_done = 1'b1;
                nxt_boot_pin_sampled = ~misc_sync_ff[IDX_BOOT];
            end
            else
            begin
                nxt_boot_cnt = boot_cnt_ff + 1'b1;
            end
        end
    end

    // Boot capture registers
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            boot_cnt_ff <= '0;
            boot_done_ff <= 1'b0;
            boot_pin_sampled_ff <= 1'b0;
        end
        else
        begin
            boot_cnt_ff <= nxt_boot_cnt;
            boot_done_ff <= nxt_boot_done;
            boot_pin_sampled_ff <= nxt_boot_pin_sampled;
        end
    end

    // Registered outputs toward the pins and the interrupt controller
    assign ext_irq_pending_out = pending_ff;
    assign debug_enable_out = dbg_en_ff;
    assign ext_regulator_override_enable_out = ext_reg_ff;
    assign irq_c_select_out = sel_c_ff;
    assign irq_d_select_out = sel_d_ff;

endmodule : gidc_top

`default_nettype wire
